/* File: rtl/fsq_sequencer.sv */
// flash command sequencer: mode, command and status registers
//
// Local design decisions: the plain strobed port and the register addresses.
module fsq_sequencer
#(
  parameter logic [15:0] ERASE_UNITS = 16'd8,
  parameter logic [15:0] NVM_UNITS   = 16'd4
)
(
  input  wire logic                     clk,
  input  wire logic                     reset,
  input  wire logic [fsq_pkg::ADDR_W-1:0] bus_addr,
  input  wire logic [31:0]              bus_wdata,
  input  wire logic                     bus_wr,
  input  wire logic                     bus_rd,
  output logic      [31:0]              bus_rdata,
  input  wire logic                     latch_we,
  input  wire logic [7:0]               latch_addr,
  input  wire logic [31:0]              latch_wdata,
  input  wire logic                     erase_pin,
  output fsq_pkg::fsq_arr_t             array_req,
  output logic                          array_read_ok,
  output logic                          security_active,
  output logic                          irq
);
  import fsq_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // whole state of the block
  typedef struct packed {
    fsq_st_t                         state;
    logic                            ready_ie;
    logic                            lock_violation_flag_ie;
    logic                            command_error_flag_ie;
    logic                            skip_erase_bit;
    logic [1:0]                      wait_states;
    logic [7:0]                      microsecond_cycle_count;
    logic                            ready_flag;
    logic                            command_error_flag;
    logic                            lock_violation_flag;
    logic                            secure;
    logic [REGIONS-1:0]              lock_cell;
    logic [OPT_BITS-1:0]             opt_cell;
    logic [PAGE_WORDS-1:0][31:0]     latch;
    logic [3:0]                      op;
    logic [PAGE_W-1:0]               page;
    logic [WIDX_W-1:0]               widx;
    logic [7:0]                      timer;
    logic [15:0]                     units;
    logic [31:0]                     rdata;
    logic                            irq;
    logic                            read_ok;
    fsq_arr_t                        arr;
    logic                            pin_s1;
    logic                            pin_s2;
    logic                            pin_prev;
  } fsq_state_t;

  fsq_state_t s_reg;
  fsq_state_t s_next;

  ////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic key_ok(input logic [31:0] w);
    key_ok = (w[KEY_LSB +: 8] == CMD_KEY);
  endfunction : key_ok

  function automatic logic code_ok(input logic [3:0] c);
    code_ok = (c == OP_NONE) || (c == OP_PROG) || (c == OP_LOCK) ||
              (c == OP_PROG_LOCK) || (c == OP_UNLOCK) ||
              (c == OP_ERASE_ALL) || (c == OP_OPT_SET) ||
              (c == OP_OPT_CLR) || (c == OP_SEC_SET);
  endfunction : code_ok

  // any page of a region selects it
  function automatic logic [REGION_W-1:0] region_of(
    input logic [PAGE_W-1:0] p);
    region_of = p[PAGE_W-1 -: REGION_W];
  endfunction : region_of

  logic              cmd_wr;
  logic              stat_rd;
  logic [3:0]        cmd_code;
  logic [PAGE_W-1:0] cmd_page;

  assign cmd_wr   = bus_wr && (bus_addr == CMD_OFF);
  assign stat_rd  = bus_rd && (bus_addr == STATUS_OFF);
  assign cmd_code = bus_wdata[3:0];
  assign cmd_page = bus_wdata[PAGE_LSB +: PAGE_W];

  ////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb
  begin
    logic tick;
    tick   = (s_reg.timer == 8'h00);
    s_next = s_reg;
    s_next.arr.we         = 1'b0;
    s_next.arr.erase_page = 1'b0;
    s_next.arr.erase_all  = 1'b0;
    s_next.rdata          = 32'h0000_0000;

    // erase pin: two stages before anything looks at it
    s_next.pin_s1   = erase_pin;
    s_next.pin_s2   = s_reg.pin_s1;
    s_next.pin_prev = s_reg.pin_s2;

    // step timer, one unit per count+1 cycles
    if (s_reg.state != ST_IDLE && s_reg.state != ST_FINISH)
    begin
      s_next.timer = tick ? s_reg.microsecond_cycle_count
                          : s_reg.timer - 8'h01;
    end

    // latch wraps every page; byte lanes are not decoded
    if (latch_we)
    begin
      s_next.latch[latch_addr[WIDX_W+1:2]] = latch_wdata;
    end

    // register reads, answer in the next cycle only
    if (bus_rd)
    begin
      if (bus_addr == MODE_OFF)
      begin
        s_next.rdata[MODE_RDY_IE]  = s_reg.ready_ie;
        s_next.rdata[MODE_LOCK_IE] = s_reg.lock_violation_flag_ie;
        s_next.rdata[MODE_ERR_IE]  = s_reg.command_error_flag_ie;
        s_next.rdata[MODE_SKIP]    = s_reg.skip_erase_bit;
        s_next.rdata[MODE_WS_LSB +: 2]  = s_reg.wait_states;
        s_next.rdata[MODE_CNT_LSB +: 8] = s_reg.microsecond_cycle_count;
      end
      else if (bus_addr == STATUS_OFF)
      begin
        s_next.rdata[ST_RDY]   = s_reg.ready_flag;
        s_next.rdata[ST_LOCK_VIOLATION_FLAG] = s_reg.lock_violation_flag;
        s_next.rdata[ST_CMDE]  = s_reg.command_error_flag;
        s_next.rdata[ST_SEC]   = s_reg.secure;
        s_next.rdata[ST_OPT_LSB +: OPT_BITS] = ~s_reg.opt_cell;
        s_next.rdata[ST_LOCK_LSB +: REGIONS] = ~s_reg.lock_cell;
        s_next.command_error_flag  = 1'b0;
        s_next.lock_violation_flag = 1'b0;
      end
    end

    // mode register write
    if (bus_wr && bus_addr == MODE_OFF)
    begin
      s_next.ready_ie       = bus_wdata[MODE_RDY_IE];
      s_next.lock_violation_flag_ie       = bus_wdata[MODE_LOCK_IE];
      s_next.command_error_flag_ie       = bus_wdata[MODE_ERR_IE];
      s_next.skip_erase_bit = bus_wdata[MODE_SKIP];
      s_next.wait_states    = bus_wdata[MODE_WS_LSB +: 2];
      s_next.microsecond_cycle_count = bus_wdata[MODE_CNT_LSB +: 8];
    end

    // a command write drops ready in any state but ST_FINISH, where ready rises instead
    if (cmd_wr)
    begin
      s_next.ready_flag = 1'b0;
    end

    // sequencer
    case (s_reg.state)
      ST_IDLE:
      begin
        s_next.timer = s_reg.microsecond_cycle_count;
        if (cmd_wr)
        begin
          s_next.op   = cmd_code;
          s_next.page = cmd_page;
          s_next.widx = '0;
          s_next.state = ST_FINISH;
          if (!key_ok(bus_wdata) || !code_ok(cmd_code))
            s_next.command_error_flag = 1'b1;
          else if (cmd_code == OP_PROG || cmd_code == OP_PROG_LOCK)
          begin
            if (!s_reg.lock_cell[region_of(cmd_page)])
            begin
              s_next.lock_violation_flag = 1'b1;
            end
            else if (!s_reg.skip_erase_bit)
            begin
              s_next.state          = ST_ERASE;
              s_next.units          = ERASE_UNITS;
              s_next.arr.erase_page = 1'b1;
              s_next.arr.addr       = {cmd_page, {WIDX_W{1'b0}}};
            end
            else
              s_next.state = ST_PROG;
          end
          else if (cmd_code == OP_ERASE_ALL)
          begin
            if (s_reg.lock_cell != {REGIONS{1'b1}})
            begin
              s_next.lock_violation_flag = 1'b1;
            end
            else
            begin
              s_next.state         = ST_ERASE;
              s_next.units         = ERASE_UNITS;
              s_next.arr.erase_all = 1'b1;
            end
          end
          else if (cmd_code != OP_NONE)
          begin
            s_next.state = ST_NVM;
            s_next.units = NVM_UNITS;
          end
        end
        else if (s_reg.pin_s2 && !s_reg.pin_prev)
        begin
          // erase pin clears everything, security last
          s_next.ready_flag    = 1'b0;
          s_next.state         = ST_EXT;
          s_next.units         = ERASE_UNITS;
          s_next.arr.erase_all = 1'b1;
        end
      end
      ST_ERASE:
      begin
        if (tick)
        begin
          s_next.units = s_reg.units - 16'h0001;
          if (s_reg.units == 16'h0000)
          begin
            s_next.state = (s_reg.op == OP_ERASE_ALL) ? ST_FINISH
                                                      : ST_PROG;
          end
        end
      end
      ST_PROG:
      begin
        // one latch word per step
        if (tick)
        begin
          s_next.arr.we    = 1'b1;
          s_next.arr.addr  = {s_reg.page, s_reg.widx};
          s_next.arr.wdata = s_reg.latch[s_reg.widx];
          s_next.widx      = s_reg.widx + 1'b1;
          if (s_reg.widx == WIDX_W'(PAGE_WORDS - 1))
          begin
            s_next.state = ST_FINISH;
            if (s_reg.op == OP_PROG_LOCK)
            begin
              s_next.state = ST_NVM;
              s_next.units = NVM_UNITS;
            end
          end
        end
      end
      ST_NVM:
      begin
        if (tick)
        begin
          s_next.units = s_reg.units - 16'h0001;
          if (s_reg.units == 16'h0000)
          begin
            s_next.state = ST_FINISH;
            case (s_reg.op)
              OP_LOCK, OP_PROG_LOCK:
                s_next.lock_cell[region_of(s_reg.page)] = 1'b0;
              OP_UNLOCK:
                s_next.lock_cell[region_of(s_reg.page)] = 1'b1;
              OP_OPT_SET:
                if (s_reg.page < PAGE_W'(OPT_BITS))
                  s_next.opt_cell[s_reg.page[0]] = 1'b0;
              OP_OPT_CLR:
                if (s_reg.page < PAGE_W'(OPT_BITS))
                  s_next.opt_cell[s_reg.page[0]] = 1'b1;
              OP_SEC_SET:
                s_next.secure = 1'b1;
              OP_UNSEC:
                s_next.secure = 1'b0;
              default:
                s_next.state = ST_FINISH;
            endcase
          end
        end
      end
      ST_EXT:
      begin
        if (tick)
        begin
          s_next.units = s_reg.units - 16'h0001;
          if (s_reg.units == 16'h0000)
          begin
            s_next.lock_cell = {REGIONS{1'b1}};
            s_next.opt_cell  = {OPT_BITS{1'b1}};
            s_next.op        = OP_UNSEC;
            s_next.state     = ST_NVM;
            s_next.units     = NVM_UNITS;
          end
        end
      end
      ST_FINISH:
      begin
        s_next.ready_flag = 1'b1;
        s_next.state      = ST_IDLE;
      end
      default: s_next.state = ST_IDLE;
    endcase

    // array stays readable except while it is erased or written
    s_next.read_ok = !(s_next.state inside
                       {ST_ERASE, ST_PROG, ST_EXT});
    // level interrupt, drops when the flags drop
    s_next.irq = (s_next.ready_flag && s_next.ready_ie) ||
                 (s_next.lock_violation_flag && s_next.lock_violation_flag_ie) ||
                 (s_next.command_error_flag && s_next.command_error_flag_ie);
  end

  ////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s_reg            <= '0;
      s_reg.state      <= ST_IDLE;
      s_reg.ready_flag <= 1'b1;
      s_reg.read_ok    <= 1'b1;
      s_reg.lock_cell  <= LOCK_CELL_RST;
      s_reg.opt_cell   <= OPT_CELL_RST;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign bus_rdata       = s_reg.rdata;
  assign array_req       = s_reg.arr;
  assign array_read_ok   = s_reg.read_ok;
  assign security_active = s_reg.secure;
  assign irq             = s_reg.irq;

  ////////////////////////////////////////////////////////////////////////
  // checks
  logic idle_cmd;
  logic prog_cmd;
  assign idle_cmd = cmd_wr && (s_reg.state == ST_IDLE) && key_ok(bus_wdata);
  assign prog_cmd = idle_cmd &&
                    (cmd_code == OP_PROG || cmd_code == OP_PROG_LOCK);

  sequence prog_unlocked_seq;
    prog_cmd && s_reg.lock_cell[region_of(cmd_page)];
  endsequence

  sequence no_array_seq;
    !array_req.we && !array_req.erase_page && !array_req.erase_all;
  endsequence

  a_ready_drop: assert property (@(posedge clk) disable iff (reset)
    cmd_wr |=> !s_reg.ready_flag)
    else $error("ready stayed high after a command write");

  a_ready_rise: assert property (@(posedge clk) disable iff (reset)
    $rose(s_reg.ready_flag) |-> $past(s_reg.state) == ST_FINISH)
    else $error("ready rose without a finished command");

  a_ready_irq: assert property (@(posedge clk) disable iff (reset)
    (s_reg.ready_flag && s_reg.ready_ie) |-> irq)
    else $error("ready with enable did not raise interrupt");

  a_bad_key: assert property (@(posedge clk) disable iff (reset)
    (cmd_wr && s_reg.state == ST_IDLE &&
     !(key_ok(bus_wdata) && code_ok(cmd_code)))
      |=> s_reg.command_error_flag ##0 no_array_seq [*2])
    else $error("bad key not flagged or array touched");

  a_read_clears: assert property (@(posedge clk) disable iff (reset)
    stat_rd |=> !s_reg.command_error_flag && !s_reg.lock_violation_flag)
    else $error("status read left an error flag set");

  a_locked_abort: assert property (@(posedge clk) disable iff (reset)
    (prog_cmd && !s_reg.lock_cell[region_of(cmd_page)])
      |=> s_reg.lock_violation_flag ##0 no_array_seq [*3])
    else $error("locked page write not aborted");

  a_erase_first: assert property (@(posedge clk) disable iff (reset)
    (prog_unlocked_seq ##0 !s_reg.skip_erase_bit)
      |=> array_req.erase_page && s_reg.state == ST_ERASE)
    else $error("page not erased before programming");

  a_skip_erase: assert property (@(posedge clk) disable iff (reset)
    (prog_unlocked_seq ##0 s_reg.skip_erase_bit)
      |=> s_reg.state == ST_PROG && !array_req.erase_page)
    else $error("erase done although skip-erase set");

  a_ea_refused: assert property (@(posedge clk) disable iff (reset)
    (idle_cmd && cmd_code == OP_ERASE_ALL && !(&s_reg.lock_cell))
      |=> s_reg.lock_violation_flag && !array_req.erase_all)
    else $error("erase-all ran with a locked region");

  a_sec_status: assert property (@(posedge clk) disable iff (reset)
    stat_rd |=> bus_rdata[ST_SEC] == $past(s_reg.secure))
    else $error("security status bit wrong");

endmodule : fsq_sequencer

/* File: rtl/fsq_pkg.sv */
// constants and carrier types for the flash command sequencer
//
// Notes on behaviour
// - codes 0x01 program, 0x03 program+lock, 0x08 erase-all
// - code 0x02 locks region, 0x04 unlocks
// - code 0x0B sets option bit, 0x0D clears
// - command write drops ready except during ST_FINISH; rises when finished
// - ready with its enable raises interrupt
// - bad key or code: array untouched, error flag
// - status read clears both error flags
// - program into locked region aborts, lock error
// - skip-erase clear erases page before programming
// - one-page latch addressed modulo page size
// - programming starts on valid program command write
// - program-and-lock locks region after programming
// - erase-all refused while any region locked
// - lock region chosen by page at bit 8
// - unlock stores 1, lock 0; status reads inverted
// - array reads stay available during bit commands
// - option number out of range has no effect
// - clear stores 1, set 0; status reads inverted
// - 0x0F sets security; only erase pin or reset clears
// - status shows security bit while active
package fsq_pkg;

  ////////////////////////////////////////////////////////////////////////
  // register map and field layout
  localparam int          ADDR_W       = 8;
  localparam logic [7:0]  MODE_OFF     = 8'h60;
  localparam logic [7:0]  CMD_OFF      = 8'h64;
  localparam logic [7:0]  STATUS_OFF   = 8'h68;
  localparam logic [7:0]  CMD_KEY      = 8'h5A;
  localparam int          KEY_LSB      = 24;
  localparam int          PAGE_LSB     = 8;
  localparam int          PAGE_W       = 10;
  localparam int          REGION_W     = 4;
  localparam int          REGIONS      = 16;
  localparam int          OPT_BITS     = 2;
  localparam int          WIDX_W       = 6;
  localparam int          PAGE_WORDS   = 64;
  localparam int          MODE_RDY_IE  = 0;
  localparam int          MODE_LOCK_IE = 2;
  localparam int          MODE_ERR_IE  = 3;
  localparam int          MODE_SKIP    = 7;
  localparam int          MODE_WS_LSB  = 8;
  localparam int          MODE_CNT_LSB = 16;
  localparam int          ST_RDY       = 0;
  localparam int          ST_LOCK_VIOLATION_FLAG     = 2;
  localparam int          ST_CMDE      = 3;
  localparam int          ST_SEC       = 4;
  localparam int          ST_OPT_LSB   = 8;
  localparam int          ST_LOCK_LSB  = 16;

  ////////////////////////////////////////////////////////////////////////
  // command codes; OP_UNSEC is internal to the erase-pin sequence
  localparam logic [3:0]  OP_NONE      = 4'h0;
  localparam logic [3:0]  OP_PROG      = 4'h1;
  localparam logic [3:0]  OP_LOCK      = 4'h2;
  localparam logic [3:0]  OP_PROG_LOCK = 4'h3;
  localparam logic [3:0]  OP_UNLOCK    = 4'h4;
  localparam logic [3:0]  OP_ERASE_ALL = 4'h8;
  localparam logic [3:0]  OP_OPT_SET   = 4'hB;
  localparam logic [3:0]  OP_OPT_CLR   = 4'hD;
  localparam logic [3:0]  OP_UNSEC     = 4'hE;
  localparam logic [3:0]  OP_SEC_SET   = 4'hF;

  ////////////////////////////////////////////////////////////////////////
  // reset values of the non-volatile cells (1 = unlocked / cleared)
  localparam logic [15:0] LOCK_CELL_RST = 16'hFFFF;
  localparam logic [1:0]  OPT_CELL_RST  = 2'b11;

  typedef enum logic [5:0] {
    ST_IDLE   = 6'b00_0001,
    ST_ERASE  = 6'b00_0010,
    ST_PROG   = 6'b00_0100,
    ST_NVM    = 6'b00_1000,
    ST_EXT    = 6'b01_0000,
    ST_FINISH = 6'b10_0000
  } fsq_st_t;

  // request bundle toward the flash array macro
  typedef struct packed {
    logic        we;
    logic        erase_page;
    logic        erase_all;
    logic [15:0] addr;
    logic [31:0] wdata;
  } fsq_arr_t;

endpackage : fsq_pkg

/* File: tb/fsq_sequencer_tb_top.sv */
// self-checking bench for the flash command sequencer
module fsq_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import fsq_pkg::*;

  logic              clk;
  logic              reset;
  logic [ADDR_W-1:0] bus_addr;
  logic [31:0]       bus_wdata;
  logic              bus_wr;
  logic              bus_rd;
  logic [31:0]       bus_rdata;
  logic              latch_we;
  logic [7:0]        latch_addr;
  logic [31:0]       latch_wdata;
  logic              erase_pin;
  fsq_arr_t          array_req;
  logic              array_read_ok;
  logic              security_active;
  logic              irq;
  int                mismatches;
  int                checked;
  int                er_pg;
  int                er_all;
  int                we_cnt;
  int                bad_dat;
  int                rd_low;
  logic [31:0]       rd_val;
  logic [15:0]       salt;
  logic [9:0]        exp_page;

  // short unit counts keep every erase and bit command to a few dozen cycles
  fsq_sequencer #(.ERASE_UNITS(16'd1), .NVM_UNITS(16'd1)) dut_u
  (
    .clk             (clk),
    .reset           (reset),
    .bus_addr        (bus_addr),
    .bus_wdata       (bus_wdata),
    .bus_wr          (bus_wr),
    .bus_rd          (bus_rd),
    .bus_rdata       (bus_rdata),
    .latch_we        (latch_we),
    .latch_addr      (latch_addr),
    .latch_wdata     (latch_wdata),
    .erase_pin       (erase_pin),
    .array_req       (array_req),
    .array_read_ok   (array_read_ok),
    .security_active (security_active),
    .irq             (irq)
  );

  // 100 ns period
  always #50 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////
  // tally of array requests; word data and page judged as they pass
  always @(posedge clk)
  begin
    if (array_req.erase_page === 1'b1) er_pg++;
    if (array_req.erase_all === 1'b1) er_all++;
    if (array_read_ok !== 1'b1) rd_low++;
    if (array_req.we === 1'b1)
    begin
      we_cnt++;
      if (array_req.wdata !== {salt, 10'h000, array_req.addr[5:0]}
          || array_req.addr[15:6] !== exp_page) bad_dat++;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_wr    <= 1'b1;
    @(posedge clk);
    bus_wr    <= 1'b0;
  endtask : bus_write

  // data stand only in the cycle after the strobe, so sample just then
  task automatic bus_read(input logic [7:0] a);
    @(posedge clk);
    bus_addr <= a;
    bus_rd   <= 1'b1;
    @(posedge clk);
    bus_rd   <= 1'b0;
    #1;
    rd_val = bus_rdata;
  endtask : bus_read

  task automatic status_is(input logic [31:0] exp);
    bus_read(STATUS_OFF);
    check(rd_val, exp);
  endtask : status_is

  // completion seen through irq, so a ready or error enable must be on
  task automatic run_cmd(input logic [7:0] key, input logic [3:0] code,
                         input logic [9:0] pg, input logic peek);
    int n;
    er_pg = 0;
    er_all = 0;
    we_cnt = 0;
    bad_dat = 0;
    rd_low = 0;
    bus_write(CMD_OFF, {key, 6'h00, pg, 4'h0, code});
    if (peek)
    begin
      bus_read(STATUS_OFF);
      check({31'h0, rd_val[0]}, 32'h0);
    end
    n = 0;
    repeat (3) @(posedge clk);
    while (irq !== 1'b1 && n < 2000)
    begin
      @(posedge clk);
      n++;
    end
    if (n == 2000) mismatches++;
  endtask : run_cmd

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    status_is(32'h0000_0001);
    bus_read(MODE_OFF);
    check(rd_val, 32'h0);
    check({29'h0, irq, security_active, array_read_ok}, 32'h1);
  endtask : t_reset

  // reserved codes and a bad key must leave the array alone
  task automatic t_bad();
    logic [3:0] codes [8];
    codes = '{4'h5, 4'h6, 4'h7, 4'h9, 4'hA, 4'hC, 4'hE, 4'h1};
    bus_write(MODE_OFF, 32'h0000_0001);
    foreach (codes[i])
    begin
      run_cmd((i == 7) ? 8'hA5 : CMD_KEY, codes[i], 10'h005, 1'b0);
      check(er_pg + er_all + we_cnt, 0);
      status_is(32'h0000_0009);
      status_is(32'h0000_0001);
    end
    run_cmd(CMD_KEY, OP_NONE, 10'h005, 1'b0);
    status_is(32'h0000_0001);
  endtask : t_bad

  task automatic t_prog(input logic skip, input logic [3:0] code,
                        input logic [9:0] pg, input logic [15:0] s);
    salt = s;
    exp_page = pg;
    for (int i = 0; i < 64; i++)
    begin
      @(posedge clk);
      latch_we    <= 1'b1;
      latch_addr  <= {i[5:0], 2'b00};
      latch_wdata <= {s, 10'h000, i[5:0]};
    end
    @(posedge clk);
    latch_we <= 1'b0;
    // 16 cycles of 100 ns cover 1.6 us, so the step timer really counts
    bus_write(MODE_OFF, {8'h00, 8'h0F, 8'h00, skip, 7'h01});
    run_cmd(CMD_KEY, code, pg, 1'b1);
    check(er_pg, skip ? 0 : 1);
    check(we_cnt, 64);
    check(bad_dat, 0);
  endtask : t_prog

  task automatic t_lock();
    bus_write(MODE_OFF, 32'h000A_0001);
    run_cmd(CMD_KEY, OP_LOCK, 10'h007, 1'b0);
    check(rd_low, 0);
    status_is(32'h0001_0001);
    run_cmd(CMD_KEY, OP_PROG, 10'h005, 1'b0);
    check(er_pg + we_cnt, 0);
    status_is(32'h0001_0005);
    // ready enable off: only the lock error can raise irq here
    bus_write(MODE_OFF, 32'h0000_0004);
    run_cmd(CMD_KEY, OP_ERASE_ALL, 10'h000, 1'b0);
    check(er_all, 0);
    check({31'h0, irq}, 32'h1);
    status_is(32'h0001_0005);
    @(posedge clk);
    #1;
    check({31'h0, irq}, 32'h0);
    bus_write(MODE_OFF, 32'h0000_0001);
    run_cmd(CMD_KEY, OP_UNLOCK, 10'h03F, 1'b0);
    check(rd_low, 0);
    status_is(32'h0000_0001);
    run_cmd(CMD_KEY, OP_ERASE_ALL, 10'h000, 1'b1);
    check(er_all, 1);
  endtask : t_lock

  task automatic opt_step(input logic [3:0] c, input logic [9:0] n,
                          input logic [31:0] exp);
    run_cmd(CMD_KEY, c, n, 1'b0);
    check(rd_low, 0);
    status_is(exp);
  endtask : opt_step

  task automatic t_opt();
    opt_step(OP_OPT_SET, 10'd0, 32'h0000_0101);
    opt_step(OP_OPT_SET, 10'd1, 32'h0000_0301);
    opt_step(OP_OPT_SET, 10'd2, 32'h0000_0301);
    opt_step(OP_OPT_CLR, 10'd0, 32'h0000_0201);
    opt_step(OP_OPT_CLR, 10'd3, 32'h0000_0201);
    opt_step(OP_OPT_CLR, 10'd1, 32'h0000_0001);
  endtask : t_opt

  // erase pin must wipe everything before security drops
  task automatic t_sec();
    int n;
    opt_step(OP_OPT_SET, 10'd0, 32'h0000_0101);
    run_cmd(CMD_KEY, OP_LOCK, 10'h000, 1'b0);
    run_cmd(CMD_KEY, OP_SEC_SET, 10'h000, 1'b0);
    check({31'h0, security_active}, 32'h1);
    status_is(32'h0001_0111);
    er_all = 0;
    @(posedge clk);
    erase_pin <= 1'b1;
    repeat (4) @(posedge clk);
    erase_pin <= 1'b0;
    n = 0;
    while (security_active !== 1'b0 && n < 2000)
    begin
      @(posedge clk);
      n++;
    end
    check({31'h0, security_active}, 32'h0);
    check(er_all, 1);
    repeat (3) @(posedge clk);
    status_is(32'h0000_0001);
  endtask : t_sec

  ////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop

  // watchdog: all scenarios need a few thousand cycles at most
  initial
  begin
    repeat (30000) @(posedge clk);
    mismatches++;
    report_and_stop();
  end

  // main sequence
  initial
  begin
    clk = 1'b0;
    reset = 1'b1;
    bus_addr = '0;
    bus_wdata = '0;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    latch_we = 1'b0;
    latch_addr = '0;
    latch_wdata = '0;
    erase_pin = 1'b0;
    mismatches = 0;
    checked = 0;
    salt = '0;
    exp_page = '0;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_bad();
    t_prog(1'b0, OP_PROG, 10'h005, 16'hC0DE);
    t_prog(1'b1, OP_PROG, 10'h005, 16'h0F0F);
    t_lock();
    t_prog(1'b0, OP_PROG_LOCK, 10'h085, 16'hBEEF);
    status_is(32'h0004_0001);
    run_cmd(CMD_KEY, OP_UNLOCK, 10'h080, 1'b0);
    t_opt();
    t_sec();
    report_and_stop();
  end

endmodule : fsq_sequencer_tb_top
